// ===== common/scs_pkg.sv
package scs_pkg;

	// Operating mode setting values
	localparam logic [7:0] MODE_POS   = 8'h01;
	localparam logic [7:0] MODE_SPEED = 8'h02;

	// Input function codes
	localparam logic [7:0] FN_NONE      = 8'h00;
	localparam logic [7:0] FN_SERVO_ON  = 8'h65;
	localparam logic [7:0] FN_ALM_RESET = 8'h66;
	localparam logic [7:0] FN_TRIGGER   = 8'h6c;
	localparam logic [7:0] FN_TRQ_LIMIT = 8'h6d;
	localparam logic [7:0] FN_POS_SEL0  = 8'h6f;
	localparam logic [7:0] FN_POS_SEL1  = 8'h70;
	localparam logic [7:0] FN_POS_SEL2  = 8'h71;
	localparam logic [7:0] FN_SPD_SEL0  = 8'h72;
	localparam logic [7:0] FN_SPD_SEL1  = 8'h73;
	localparam logic [7:0] FN_ESTOP     = 8'h15;
	localparam logic [7:0] FN_REV_LIMIT = 8'h16;
	localparam logic [7:0] FN_FWD_LIMIT = 8'h17;

	// Index of the input that may carry position select bit 2
	localparam int SEL2_INPUT = 4;

	// Alarm bit positions: alarms 13, 14, 15
	localparam int ALM_REV   = 0;
	localparam int ALM_FWD   = 1;
	localparam int ALM_ESTOP = 2;

	// Widths
	localparam int ROT_W  = 16;
	localparam int PUL_W  = 24;
	localparam int SPD_W  = 16;
	localparam int POS_W  = 48;
	localparam int TGT_W  = ROT_W + PUL_W + SPD_W;
	localparam int NTGT   = 8;

	// Limits and scaling
	localparam logic signed [31:0] ROT_LIMIT   = 32'sh0000_7530;
	localparam logic signed [31:0] SPEED_LIMIT = 32'sh0000_1388;
	localparam logic signed [31:0] PULSES_REV  = 32'sh0000_2710;
	localparam logic signed [31:0] PULSE_LIMIT = PULSES_REV - 32'sh1;

	// Speed source codes
	localparam logic [1:0] SRC_ANALOG = 2'h0;

	typedef enum logic [1:0] {
		scs_mode_none  = 2'b00,
		scs_mode_speed = 2'b01,
		scs_mode_pos   = 2'b10
	} scs_mode_t;

	typedef enum logic [1:0] {
		scs_mv_idle  = 2'b00,
		scs_mv_fetch = 2'b01,
		scs_mv_load  = 2'b10
	} scs_mv_state_t;

	// Symmetric saturation to +/- lim
	function automatic logic signed [31:0] scs_clamp(input logic signed [31:0] v,
		input logic signed [31:0] lim);
		logic signed [31:0] r;
		r = v;
		if (v > lim) begin
			r = lim;
		end else if (v < -lim) begin
			r = -lim;
		end
		return r;
	endfunction

endpackage

// ===== core/scs_role_map.sv
`timescale 1ns/10ps
module scs_role_map (
	input  wire logic [7:0]          level,
	input  wire logic [63:0]         codes,
	input  wire scs_pkg::scs_mode_t  mode,
	output logic                     servo_enable_in,
	output logic                     torque_limit_enable_in,
	output logic                     speed_select_bit0,
	output logic                     speed_select_bit1,
	output logic                     alarm_reset_in,
	output logic                     position_trigger_in,
	output logic                     position_select_bit0,
	output logic                     position_select_bit1,
	output logic                     position_select_bit2,
	output logic [2:0]               limit_idle
);

	// True when any input assigned to fn sits at level want; code 0 never matches
	function automatic logic hit(input logic [63:0] c, input logic [7:0] lv,
		input logic [7:0] fn, input logic want);
		logic r;
		r = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (c[i*8 +: 8] == fn && fn != scs_pkg::FN_NONE && lv[i] == want) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

	logic spd;
	logic pos;

	always_comb begin
		spd = (mode == scs_pkg::scs_mode_speed);
		pos = (mode == scs_pkg::scs_mode_pos);
		servo_enable_in        = hit(codes, level, scs_pkg::FN_SERVO_ON, 1'b1);
		alarm_reset_in         = hit(codes, level, scs_pkg::FN_ALM_RESET, 1'b1);
		torque_limit_enable_in = spd & hit(codes, level, scs_pkg::FN_TRQ_LIMIT, 1'b1);
		speed_select_bit0      = spd & hit(codes, level, scs_pkg::FN_SPD_SEL0, 1'b1);
		speed_select_bit1      = spd & hit(codes, level, scs_pkg::FN_SPD_SEL1, 1'b1);
		position_trigger_in    = pos & hit(codes, level, scs_pkg::FN_TRIGGER, 1'b1);
		position_select_bit0   = pos & hit(codes, level, scs_pkg::FN_POS_SEL0, 1'b1);
		position_select_bit1   = pos & hit(codes, level, scs_pkg::FN_POS_SEL1, 1'b1);
		position_select_bit2   = pos & level[scs_pkg::SEL2_INPUT]
			& (codes[scs_pkg::SEL2_INPUT*8 +: 8] == scs_pkg::FN_POS_SEL2);
		limit_idle[scs_pkg::ALM_REV]   = hit(codes, level, scs_pkg::FN_REV_LIMIT, 1'b0);
		limit_idle[scs_pkg::ALM_FWD]   = hit(codes, level, scs_pkg::FN_FWD_LIMIT, 1'b0);
		limit_idle[scs_pkg::ALM_ESTOP] = hit(codes, level, scs_pkg::FN_ESTOP, 1'b0);
	end

endmodule

// ===== core/scs_target_mem.sv
`timescale 1ns/10ps
module scs_target_mem (
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire logic                      wr_en,
	input  wire logic [2:0]                wr_addr,
	input  wire logic [scs_pkg::TGT_W-1:0] wr_data,
	input  wire logic [2:0]                rd_addr,
	output logic [scs_pkg::TGT_W-1:0]      rd_data
);

	logic [scs_pkg::TGT_W-1:0] mem [scs_pkg::NTGT];
	logic [scs_pkg::TGT_W-1:0] rd_data_q;
	logic [scs_pkg::TGT_W-1:0] rd_data_d;

	always_comb begin
		rd_data_d = mem[rd_addr];
	end

	// Storage has no reset; targets are loaded by software before use
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	assign rd_data = rd_data_q;

endmodule

// ===== core/scs_command_select.sv
// Operation
// - Mode setting 02 selects speed at restart
// - Mode setting 01 selects position at restart
// - Speed mode input codes map roles
// - Position mode input codes map roles
// - Code 113 on input five selects bit2
// - Code 0 input is ignored
// - Assigned idle limits raise alarms 13-15
// - Alarm reset input or restart clears faults
// - Speed bits pick analog or three presets
// - Analog source follows reference voltage sample
// - Signed speed commands set rotation direction
// - Input ON decodes as logic one
// - Position bits index one of eight targets
// - Rotation clamped 30000, pulse to encoder max
// - Command type 0 absolute, 1 relative
// - Motor powered only while servo enable active
// - Trigger rising edge latches target, starts move
// - Target is turns times count plus pulses
`timescale 1ns/10ps
module scs_command_select (
	input  wire logic                       clk,
	input  wire logic                       reset_n,
	input  wire logic [7:0]                 din_pin,
	input  wire logic [7:0]                 input1_function_assign,
	input  wire logic [7:0]                 input2_function_assign,
	input  wire logic [7:0]                 input3_function_assign,
	input  wire logic [7:0]                 input4_function_assign,
	input  wire logic [7:0]                 input5_function_assign,
	input  wire logic [7:0]                 input6_function_assign,
	input  wire logic [7:0]                 input7_function_assign,
	input  wire logic [7:0]                 input8_function_assign,
	input  wire logic [7:0]                 operating_mode_setting,
	input  wire logic signed [15:0]         speed_preset_one,
	input  wire logic signed [15:0]         speed_preset_two,
	input  wire logic signed [15:0]         speed_preset_three,
	input  wire logic signed [15:0]         analog_speed_ref,
	input  wire logic                       position_command_type,
	input  wire logic                       target_wr_en,
	input  wire logic [2:0]                 target_wr_index,
	input  wire logic signed [15:0]         target_wr_rotation,
	input  wire logic signed [23:0]         target_wr_pulse,
	input  wire logic [15:0]                target_wr_speed,
	output logic [1:0]                      active_mode,
	output logic                            motor_power,
	output logic                            torque_limit_active,
	output logic signed [15:0]              speed_command,
	output logic [1:0]                      speed_source,
	output logic [2:0]                      limit_estop_alarm,
	output logic signed [47:0]              position_command,
	output logic [15:0]                     move_speed,
	output logic [2:0]                      target_index,
	output logic                            move_start
);

	// Pin synchroniser
	logic [7:0] din_meta_q;
	logic [7:0] din_sync_q;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			din_meta_q <= '0;
			din_sync_q <= '0;
		end else begin
			din_meta_q <= din_pin;
			din_sync_q <= din_meta_q;
		end
	end

	// Mode is caught once after reset release, which stands for a power restart
	logic [1:0]         start_q;
	logic [1:0]         start_d;
	scs_pkg::scs_mode_t mode_q;
	scs_pkg::scs_mode_t mode_d;
	logic               live;

	always_comb begin
		start_d = {start_q[0], 1'b1};
		mode_d  = mode_q;
		if (!start_q[0]) begin
			case (operating_mode_setting)
				scs_pkg::MODE_SPEED: mode_d = scs_pkg::scs_mode_speed;
				scs_pkg::MODE_POS:   mode_d = scs_pkg::scs_mode_pos;
				default:             mode_d = scs_pkg::scs_mode_none;
			endcase
		end
		live = start_q[1];
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			start_q <= 2'h0;
			mode_q  <= scs_pkg::scs_mode_none;
		end else begin
			start_q <= start_d;
			mode_q  <= mode_d;
		end
	end

	// Input role decode
	logic       servo_en;
	logic       trq_en;
	logic       spd_sel0;
	logic       spd_sel1;
	logic       alm_clr;
	logic       trig;
	logic       pos_sel0;
	logic       pos_sel1;
	logic       pos_sel2;
	logic [2:0] limit_idle;

	scs_role_map u_role_map (
		.level                  (din_sync_q),
		.codes                  ({input8_function_assign, input7_function_assign,
		                          input6_function_assign, input5_function_assign,
		                          input4_function_assign, input3_function_assign,
		                          input2_function_assign, input1_function_assign}),
		.mode                   (mode_q),
		.servo_enable_in        (servo_en),
		.torque_limit_enable_in (trq_en),
		.speed_select_bit0      (spd_sel0),
		.speed_select_bit1      (spd_sel1),
		.alarm_reset_in         (alm_clr),
		.position_trigger_in    (trig),
		.position_select_bit0   (pos_sel0),
		.position_select_bit1   (pos_sel1),
		.position_select_bit2   (pos_sel2),
		.limit_idle             (limit_idle)
	);

	// Alarms and drive enable
	logic [2:0] alarm_q;
	logic [2:0] alarm_d;
	logic       power_q;
	logic       power_d;
	logic       trq_q;
	logic       trq_d;
	logic [2:0] alarm_set;

	always_comb begin
		alarm_set = live ? limit_idle : 3'h0;
		alarm_d   = (alarm_q & ~{3{alm_clr}}) | alarm_set;
		power_d   = live & servo_en & (alarm_q == 3'h0)
			& (mode_q != scs_pkg::scs_mode_none);
		trq_d     = live & trq_en;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			alarm_q <= 3'h0;
			power_q <= 1'b0;
			trq_q   <= 1'b0;
		end else begin
			alarm_q <= alarm_d;
			power_q <= power_d;
			trq_q   <= trq_d;
		end
	end

	// Speed command source
	logic signed [15:0] speed_q;
	logic signed [15:0] speed_d;
	logic [1:0]         src_q;
	logic [1:0]         src_d;
	logic signed [31:0] preset;

	always_comb begin
		src_d  = {spd_sel1, spd_sel0};
		preset = 32'sh0;
		case (src_d)
			2'h1:    preset = 32'(speed_preset_one);
			2'h2:    preset = 32'(speed_preset_two);
			2'h3:    preset = 32'(speed_preset_three);
			default: preset = 32'sh0;
		endcase
		speed_d = 16'(scs_pkg::scs_clamp(preset, scs_pkg::SPEED_LIMIT));
		if (src_d == scs_pkg::SRC_ANALOG) begin
			speed_d = analog_speed_ref;
		end
		if (!(power_d && mode_q == scs_pkg::scs_mode_speed)) begin
			speed_d = 16'sh0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			speed_q <= 16'sh0;
			src_q   <= 2'h0;
		end else begin
			speed_q <= speed_d;
			src_q   <= src_d;
		end
	end

	// Target table, rotation and pulse clamped on the way in, speed stored as given
	logic [scs_pkg::TGT_W-1:0] wr_word;
	logic [scs_pkg::TGT_W-1:0] rd_word;
	logic [2:0]                idx_q;
	logic [2:0]                idx_d;

	always_comb begin
		wr_word = {16'(scs_pkg::scs_clamp(32'(target_wr_rotation), scs_pkg::ROT_LIMIT)),
		           24'(scs_pkg::scs_clamp(32'(target_wr_pulse), scs_pkg::PULSE_LIMIT)),
		           target_wr_speed};
	end

	scs_target_mem u_target_mem (
		.clk     (clk),
		.reset_n (reset_n),
		.wr_en   (target_wr_en),
		.wr_addr (target_wr_index),
		.wr_data (wr_word),
		.rd_addr (idx_q),
		.rd_data (rd_word)
	);

	// Move sequencer: edge, fetch, load
	scs_pkg::scs_mv_state_t st_q;
	scs_pkg::scs_mv_state_t st_d;
	logic                   trig_prev_q;
	logic                   trig_edge;
	logic signed [47:0]     pos_q;
	logic signed [47:0]     pos_d;
	logic [15:0]            mspd_q;
	logic [15:0]            mspd_d;
	logic                   start_mv_q;
	logic                   start_mv_d;
	logic signed [47:0]     rot_x;
	logic signed [47:0]     pul_x;
	logic signed [47:0]     tgt;

	always_comb begin
		trig_edge  = trig & ~trig_prev_q & power_d;
		st_d       = st_q;
		idx_d      = idx_q;
		pos_d      = pos_q;
		mspd_d     = mspd_q;
		start_mv_d = 1'b0;
		rot_x = 48'(signed'(rd_word[scs_pkg::TGT_W-1 -: scs_pkg::ROT_W]));
		pul_x = 48'(signed'(rd_word[scs_pkg::SPD_W +: scs_pkg::PUL_W]));
		tgt   = rot_x * 48'(scs_pkg::PULSES_REV) + pul_x;
		case (st_q)
			scs_pkg::scs_mv_idle: begin
				if (trig_edge) begin
					idx_d = {pos_sel2, pos_sel1, pos_sel0};
					st_d  = scs_pkg::scs_mv_fetch;
				end
			end
			scs_pkg::scs_mv_fetch: begin
				st_d = scs_pkg::scs_mv_load;
			end
			scs_pkg::scs_mv_load: begin
				pos_d      = position_command_type ? pos_q + tgt : tgt;
				mspd_d     = rd_word[scs_pkg::SPD_W-1:0];
				start_mv_d = 1'b1;
				st_d       = scs_pkg::scs_mv_idle;
			end
			default: begin
				st_d = scs_pkg::scs_mv_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_q        <= scs_pkg::scs_mv_idle;
			trig_prev_q <= 1'b0;
			idx_q       <= 3'h0;
			pos_q       <= 48'sh0;
			mspd_q      <= 16'h0;
			start_mv_q  <= 1'b0;
		end else begin
			st_q        <= st_d;
			trig_prev_q <= trig;
			idx_q       <= idx_d;
			pos_q       <= pos_d;
			mspd_q      <= mspd_d;
			start_mv_q  <= start_mv_d;
		end
	end

	assign active_mode         = mode_q;
	assign motor_power         = power_q;
	assign torque_limit_active = trq_q;
	assign speed_command       = speed_q;
	assign speed_source        = src_q;
	assign limit_estop_alarm   = alarm_q;
	assign position_command    = pos_q;
	assign move_speed          = mspd_q;
	assign target_index        = idx_q;
	assign move_start          = start_mv_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_mode_speed_caught: assert property (!start_q[0] && operating_mode_setting == scs_pkg::MODE_SPEED
		|=> mode_q == scs_pkg::scs_mode_speed) else $error("speed mode not taken");
	a_mode_held_live: assert property (start_q[0] |=> $stable(mode_q))
		else $error("mode changed without restart");
	a_power_needs_enable: assert property (power_q |-> $past(servo_en) && live)
		else $error("motor powered without enable");
	a_alarm_clear_reset: assert property (alm_clr && limit_idle == 3'h0 && live |=> alarm_q == 3'h0)
		else $error("alarm reset ignored");
	a_alarm_raise_idle: assert property (live && limit_idle[scs_pkg::ALM_ESTOP]
		|=> alarm_q[scs_pkg::ALM_ESTOP]) else $error("idle stop input did not alarm");
	a_analog_source: assert property (power_d && mode_q == scs_pkg::scs_mode_speed
		&& !spd_sel0 && !spd_sel1 |=> speed_q == $past(analog_speed_ref)) else $error("analog source not used");
	a_preset_bounded: assert property (src_q != 2'h0 |-> speed_q <= 16'sh1388 && speed_q >= -16'sh1388)
		else $error("preset speed out of range");
	a_move_after_edge: assert property (st_q == scs_pkg::scs_mv_idle && trig_edge
		|=> idx_q == {$past(pos_sel2), $past(pos_sel1), $past(pos_sel0)} ##2 move_start)
		else $error("move not started");
	a_abs_target: assert property (st_q == scs_pkg::scs_mv_load && !position_command_type
		|=> pos_q == $past(tgt)) else $error("absolute target wrong");
	a_no_edge_no_move: assert property ($past(st_q) != scs_pkg::scs_mv_load |-> !move_start)
		else $error("spurious move start");

	c_speed_preset: cover property (power_q && src_q == 2'h3);
	c_move_done: cover property (move_start && position_command_type);
	c_alarm_cleared: cover property (alarm_q != 3'h0 ##1 alarm_q == 3'h0);

endmodule

// ===== test/scs_host_model.sv
`timescale 1ns/10ps
module scs_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] want_pins,
	input  wire logic       fire,
	output logic [7:0]      din_pin,
	output logic            busy
);
	int   cnt = 0;
	logic busy_q = 1'b0;

	assign busy = busy_q;

	// Trigger sequencer: the select bits are already settled when fire
	// arrives, the trigger rises four cycles later and falls after five.
	always @(posedge clk) begin
		if (fire && !busy_q) begin
			busy_q <= 1'b1;
			cnt <= 1;
		end else if (busy_q) begin
			cnt <= cnt + 1;
			if (cnt == 12) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Input 2 carries the trigger pulse on top of its host level; other contacts follow the host
	assign din_pin = {want_pins[7:2], want_pins[1] | (busy_q && cnt >= 5 && cnt <= 9), want_pins[0]};
endmodule

// ===== test/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic                    clk, reset_n, fire, busy, position_command_type, target_wr_en;
	logic [7:0]              want, din_pin, operating_mode_setting;
	logic [7:0]              fn [8];
	logic signed [15:0]      speed_preset_one, speed_preset_two, speed_preset_three, analog_speed_ref;
	logic signed [15:0]      target_wr_rotation, speed_command;
	logic signed [23:0]      target_wr_pulse;
	logic [15:0]             target_wr_speed, move_speed;
	logic [2:0]              target_wr_index, limit_estop_alarm, target_index;
	logic [1:0]              active_mode, speed_source;
	logic                    motor_power, torque_limit_active, move_start;
	logic signed [47:0]      position_command;
	logic [31:0]             seed, r;
	int                      err_total, n_compared, e, n, j;
	int                      rot_m [8], pul_m [8], spd_m [8];
	longint                  acc, exp_q [$];

	scs_command_select u_dut (
		.clk, .reset_n, .din_pin, .operating_mode_setting,
		.input1_function_assign(fn[0]), .input2_function_assign(fn[1]),
		.input3_function_assign(fn[2]), .input4_function_assign(fn[3]),
		.input5_function_assign(fn[4]), .input6_function_assign(fn[5]),
		.input7_function_assign(fn[6]), .input8_function_assign(fn[7]),
		.speed_preset_one, .speed_preset_two, .speed_preset_three, .analog_speed_ref,
		.position_command_type, .target_wr_en, .target_wr_index, .target_wr_rotation,
		.target_wr_pulse, .target_wr_speed, .active_mode, .motor_power, .torque_limit_active,
		.speed_command, .speed_source, .limit_estop_alarm, .position_command, .move_speed,
		.target_index, .move_start
	);

	scs_host_model u_host (.clk(clk), .want_pins(want), .fire(fire), .din_pin(din_pin), .busy(busy));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic int clamp(int v, int lim);
		return v > lim ? lim : (v < -lim ? -lim : v);
	endfunction

	task automatic chk(string name, logic [63:0] exp, logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic stop_test();
		if (err_total == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic step(int c);
		repeat (c) @(posedge clk);
		#5;
	endtask

	// Reset stands for a power restart; the mode is taken at release
	task automatic restart(logic [7:0] m, logic [7:0] w);
		reset_n = 1'b0;
		operating_mode_setting = m;
		want = w;
		step(6);
		reset_n = 1'b1;
		step(3);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		stop_test();
	end

	initial begin
		seed = 32'ha311;
		err_total = 0;
		n_compared = 0;
		fire = 1'b0;
		position_command_type = 1'b0;
		target_wr_en = 1'b0;
		target_wr_index = 3'h0;
		target_wr_rotation = 16'h0000;
		target_wr_pulse = 24'h000000;
		target_wr_speed = 16'h0000;
		speed_preset_one = 16'h0000;
		speed_preset_two = 16'h0000;
		speed_preset_three = 16'h0000;
		analog_speed_ref = 16'h0000;
		fn = '{scs_pkg::FN_SERVO_ON, scs_pkg::FN_TRQ_LIMIT, scs_pkg::FN_SPD_SEL0, scs_pkg::FN_SPD_SEL1,
			scs_pkg::FN_ALM_RESET, scs_pkg::FN_REV_LIMIT, scs_pkg::FN_FWD_LIMIT, scs_pkg::FN_ESTOP};
		restart(scs_pkg::MODE_SPEED, 8'h21);
		chk("active_mode", 64'(2'b01), 64'(active_mode));
		// Servo on, reverse limit closed, forward limit and stop left open
		want = 8'h21;
		step(6);
		chk("limit_estop_alarm", 64'(3'b110), 64'(limit_estop_alarm));
		chk("motor_power", 64'(1'b0), 64'(motor_power));
		fn[5] = scs_pkg::FN_NONE;
		fn[6] = scs_pkg::FN_NONE;
		fn[7] = scs_pkg::FN_NONE;
		step(4);
		chk("limit_estop_alarm", 64'(3'b110), 64'(limit_estop_alarm));
		want = 8'h11;
		step(6);
		chk("limit_estop_alarm", 64'(3'b000), 64'(limit_estop_alarm));
		for (int k = 0; k < 12; k++) begin
			r = rnd();
			speed_preset_one = r[15:0];
			speed_preset_two = r[31:16];
			r = rnd();
			speed_preset_three = r[15:0];
			analog_speed_ref = r[31:16];
			fn[1] = k[0] ? scs_pkg::FN_TRQ_LIMIT : scs_pkg::FN_NONE;
			want = {4'h0, k[1], k[0], r[5], k < 10};
			step(5);
			e = k[1:0] == 2'd0 ? int'(analog_speed_ref) : clamp(k[1:0] == 2'd1 ? int'(speed_preset_one) :
				k[1:0] == 2'd2 ? int'(speed_preset_two) : int'(speed_preset_three), 5000);
			chk("speed_source", 64'(k[1:0]), 64'(speed_source));
			chk("speed_command", 64'(k < 10 ? e : 0), 64'(speed_command));
			chk("torque_limit_active", 64'(r[5] & k[0]), 64'(torque_limit_active));
			chk("motor_power", 64'(k < 10), 64'(motor_power));
		end
		fn = '{scs_pkg::FN_SERVO_ON, scs_pkg::FN_TRIGGER, scs_pkg::FN_POS_SEL0, scs_pkg::FN_POS_SEL1,
			scs_pkg::FN_POS_SEL2, scs_pkg::FN_NONE, scs_pkg::FN_NONE, scs_pkg::FN_NONE};
		restart(scs_pkg::MODE_POS, 8'h00);
		chk("active_mode", 64'(2'b10), 64'(active_mode));
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			rot_m[i] = int'($signed(r[15:0]));
			pul_m[i] = int'(r[31:16] % 16'd19999) - 9999;
			spd_m[i] = int'(rnd() & 32'h0000ffff);
			target_wr_en = 1'b1;
			target_wr_index = 3'(i);
			target_wr_rotation = 16'(rot_m[i]);
			target_wr_pulse = 24'(pul_m[i]);
			target_wr_speed = 16'(spd_m[i]);
			step(1);
		end
		target_wr_en = 1'b0;
		acc = 0;
		for (int p = 0; p < 16; p++) begin
			j = (p * 3) % 8;
			position_command_type = p >= 8;
			want = {3'h0, 3'(j), 2'b01};
			step(4);
			fire = 1'b1;
			step(1);
			fire = 1'b0;
			n = 0;
			while (move_start !== 1'b1 && n < 40) begin
				step(1);
				n++;
			end
			acc = (p >= 8 ? acc : 64'sd0) + longint'(clamp(rot_m[j], 30000)) * 10000 + pul_m[j];
			exp_q.push_back(acc);
			chk("move_start", 64'(1'b1), 64'(move_start));
			chk("target_index", 64'(j), 64'(target_index));
			chk("position_command", 64'(exp_q.pop_front()), 64'(position_command));
			chk("move_speed", 64'(spd_m[j]), 64'(move_speed));
			step(1);
			chk("move_start", 64'(1'b0), 64'(move_start));
			while (busy) begin
				step(1);
			end
		end
		// Any other mode setting leaves the drive without a mode and unpowered
		restart(8'h03, 8'h01);
		chk("active_mode", 64'(2'b00), 64'(active_mode));
		step(4);
		chk("motor_power", 64'(1'b0), 64'(motor_power));
		chk("speed_command", 64'(0), 64'(speed_command));
		stop_test();
	end
endmodule
